// >>> asps_ctl_model.sv
`timescale 1ns/1ps
module asps_ctl_model #(
   parameter int unsigned RECOVER = 16
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [1:0] phase_i,
   input wire logic clear_i,
   input wire logic fault_shutdown_n_i,
   output logic reset_pin_n_o,
   output logic bias_mode_select_o
);
   logic [7:0] gap;
   logic [2:0] pulse;
   // cycles spent in shutdown, saturating
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || fault_shutdown_n_i) begin
         gap <= 8'h00;
      end else if (gap != 8'hff) begin
         gap <= gap + 8'h01;
      end
   end
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         reset_pin_n_o <= 1'b0;
         bias_mode_select_o <= 1'b0;
         pulse <= 3'h0;
      end else if (pulse != 3'h0) begin
         pulse <= pulse - 3'h1;
         reset_pin_n_o <= (pulse == 3'h1);
      end else if (clear_i && !fault_shutdown_n_i && gap >= RECOVER) begin
         pulse <= 3'h3;
         reset_pin_n_o <= 1'b0;
      end else if (phase_i == 2'h0) begin
         reset_pin_n_o <= 1'b0;
         bias_mode_select_o <= 1'b0;
      end else if (!reset_pin_n_o && bias_mode_select_o && phase_i[1]) begin
         reset_pin_n_o <= 1'b1;
         bias_mode_select_o <= !phase_i[0];
      end else if (!reset_pin_n_o && phase_i == 2'h1) begin
         bias_mode_select_o <= 1'b1;
      end
   end
endmodule

// >>> asps_oc_limiter.sv
`timescale 1ns/1ps
module asps_oc_limiter #(
   parameter int unsigned OVERLOAD_CYCLES = asps_pkg::OVERLOAD_CYCLES_DEFAULT
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic enable_i,
   input wire logic pwm_i,
   input wire logic oc_high_i,
   input wire logic oc_low_i,
   output logic high_on_o,
   output logic low_on_o,
   output logic limiting_o,
   output logic persist_o
);
   localparam logic [asps_pkg::PERSIST_W-1:0] LIMIT_CNT =
      asps_pkg::PERSIST_W'(OVERLOAD_CYCLES - 1);

   logic high_block;
   logic low_block;
   logic [asps_pkg::PERSIST_W-1:0] persist_cnt;
   logic next_high_block;
   logic next_low_block;

   // a tripped transistor stays off until its own conduction phase ends
   always_comb begin
      next_high_block = high_block;
      next_low_block = low_block;
      if (!enable_i || !pwm_i) begin
         next_high_block = 1'b0;
      end
      if (!enable_i || pwm_i) begin
         next_low_block = 1'b0;
      end
      if (enable_i && oc_high_i) begin
         next_high_block = 1'b1;
      end
      if (enable_i && oc_low_i) begin
         next_low_block = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         high_block <= 1'b0;
         low_block <= 1'b0;
      end else begin
         high_block <= next_high_block;
         low_block <= next_low_block;
      end
   end

   // complementary drive, both off means high impedance
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         high_on_o <= 1'b0;
         low_on_o <= 1'b0;
      end else begin
         high_on_o <= enable_i && pwm_i && !next_high_block;
         low_on_o <= enable_i && !pwm_i && !next_low_block;
      end
   end

   // consecutive cycles spent limiting
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         persist_cnt <= '0;
         persist_o <= 1'b0;
         limiting_o <= 1'b0;
      end else begin
         limiting_o <= next_high_block || next_low_block;
         persist_o <= 1'b0;
         if (!(next_high_block || next_low_block)) begin
            persist_cnt <= '0;
         end else if (persist_cnt == LIMIT_CNT) begin
            persist_o <= 1'b1;
         end else begin
            persist_cnt <= persist_cnt + 1'b1;
         end
      end
   end
endmodule

// >>> asps_pkg.sv
package asps_pkg;
   localparam int unsigned CHANNELS = 6;
   localparam int unsigned HALF_CHANNELS = 3;
   localparam int unsigned CLK_HZ = 100_000_000;
   // overload persistence, cycles of clk_i; no documented figure
   localparam int unsigned OVERLOAD_CYCLES_DEFAULT = 1024;
   localparam int unsigned PERSIST_W = 16;

   // register map, byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_TRIPS = 8'h08;
   localparam int unsigned ADDR_DEC_W = 8;

   // control fields
   localparam int unsigned CTRL_ENABLE_BIT = 0;
   localparam int unsigned CTRL_CLR_TRIPS_BIT = 1;
   localparam logic CTRL_ENABLE_RESET = 1'b1;

   // status fields
   localparam int unsigned ST_OVERLOAD_BIT = 0;
   localparam int unsigned ST_THERMAL_BIT = 1;
   localparam int unsigned ST_WARNING_BIT = 2;
   localparam int unsigned ST_UNDERVOLT_BIT = 3;
   localparam int unsigned ST_POR_BIT = 4;
   localparam int unsigned ST_RESET_PIN_BIT = 5;
   localparam int unsigned ST_MODE_BIT = 6;
   localparam int unsigned ST_STATE_LSB = 8;
   localparam int unsigned ST_LIMIT_LSB = 16;

   localparam int unsigned TRIP_W = 16;

   // ahb-lite encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
   localparam logic [2:0] HSIZE_WORD = 3'b010;
   localparam logic HRESP_OKAY = 1'b0;

   typedef enum logic [3:0] {
      ASPS_OFF = 4'b0001,
      ASPS_PRECHARGE = 4'b0010,
      ASPS_RUN = 4'b0100,
      ASPS_SHUTDOWN = 4'b1000
   } asps_state_e;
endpackage

// >>> asps_sva.sv
`timescale 1ns/1ps
module asps_sva (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic reset_pin_n_i,
   input wire logic bias_mode_select_i,
   input wire logic temp_warning_level_i,
   input wire logic thermal_shutdown_level_i,
   input wire logic gate_drive_supply_low_i,
   input wire logic common_supply_low_i,
   input wire logic [5:0] high_on_o,
   input wire logic [5:0] low_on_o,
   input wire logic bias_precharge_control_o,
   input wire logic fault_shutdown_n_o,
   input wire logic temp_warning_n_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   wire logic off = (high_on_o | low_on_o) == 6'h00;
   wire logic [1:0] pm = {reset_pin_n_i, bias_mode_select_i};
   wire logic sd = fault_shutdown_n_o;
   // pins reach the outputs three edges late
   sequence held_s(x);
      x [*4];
   endsequence
   chk_reset_floats: assert property (held_s(!reset_pin_n_i) |-> off)
      else $error("drive under reset");
   chk_reset_sd_high: assert property (held_s(!reset_pin_n_i) |-> sd)
      else $error("shutdown low under reset");
   chk_idle_all_off: assert property (
      held_s(pm == 2'b00) |-> off && !bias_precharge_control_o) else $error("idle active");
   chk_precharge_on: assert property (
      held_s(pm == 2'b01) |-> off && bias_precharge_control_o) else $error("no precharge");
   chk_bias_excl: assert property (bias_precharge_control_o |-> off)
      else $error("bias with drive");
   chk_three_ch: assert property (
      held_s(pm == 2'b10) |-> (high_on_o[5:3] | low_on_o[5:3]) == 3'h0) else $error("upper on");
   chk_thermal_off: assert property (
      held_s(thermal_shutdown_level_i && reset_pin_n_i) |-> off && !sd) else $error("hot on");
   chk_uv_off: assert property (
      held_s((gate_drive_supply_low_i || common_supply_low_i) && reset_pin_n_i)
      |-> off && !sd) else $error("undervoltage on");
   chk_warn_low: assert property (
      held_s(temp_warning_level_i && reset_pin_n_i) |-> !temp_warning_n_o) else $error("no warn");
   chk_sd_floats: assert property ($past(!sd) && !sd |-> off)
      else $error("drive in shutdown");
endmodule
bind asps_top asps_sva u_sva (.clk_i, .rst_n_i, .reset_pin_n_i, .bias_mode_select_i,
   .temp_warning_level_i, .thermal_shutdown_level_i, .gate_drive_supply_low_i,
   .common_supply_low_i, .high_on_o, .low_on_o, .bias_precharge_control_o,
   .fault_shutdown_n_o, .temp_warning_n_o);

// >>> asps_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - each transistor has its own overcurrent detector
// - overcurrent first limits current, no shutdown
// - persistent limiting sets overload latch, outputs Hi-Z
// - warning output low above warning temperature while reset is high
// - thermal shutdown floats bridges, shutdown low
// - power-on clear resets latch until supplies up
// - undervoltage floats bridges at once, shutdown low
// - undervoltage recovers by itself when supplies return
// - reset low floats every half-bridge
// - reset low holds shutdown output high
// - reset rising edge or power-on clear clears overload latch
// - mode low, reset low: all floating
// - mode high, reset low: bias precharge active
// - mode high, reset high: six channels switch
// - mode low, reset high: channels A-C only
// - shutdown output low while shutdown holds
// - non-overload faults recover without reset
module asps_top #(
   parameter int unsigned OVERLOAD_CYCLES = asps_pkg::OVERLOAD_CYCLES_DEFAULT
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   // pins from the controller side
   input wire logic reset_pin_n_i,
   input wire logic bias_mode_select_i,
   input wire logic [asps_pkg::CHANNELS-1:0] pwm_i,
   // analog comparator results
   input wire logic [asps_pkg::CHANNELS-1:0] overcurrent_high_i,
   input wire logic [asps_pkg::CHANNELS-1:0] overcurrent_low_i,
   input wire logic temp_warning_level_i,
   input wire logic thermal_shutdown_level_i,
   input wire logic gate_drive_supply_low_i,
   input wire logic common_supply_low_i,
   input wire logic supplies_up_i,
   // power stage and status pins
   output logic [asps_pkg::CHANNELS-1:0] high_on_o,
   output logic [asps_pkg::CHANNELS-1:0] low_on_o,
   output logic bias_precharge_control_o,
   output logic fault_shutdown_n_o,
   output logic temp_warning_n_o,
   // ahb-lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic [31:0] hrdata_o
);
   localparam int unsigned SYNC_W = 3 * asps_pkg::CHANNELS + 7;

   logic [SYNC_W-1:0] sync_meta;
   logic [SYNC_W-1:0] sync_q;
   logic [SYNC_W-1:0] raw_in;
   logic reset_pin_q;
   logic reset_pin_prev;
   logic mode_q;
   logic [asps_pkg::CHANNELS-1:0] pwm_q;
   logic [asps_pkg::CHANNELS-1:0] oc_high_q;
   logic [asps_pkg::CHANNELS-1:0] oc_low_q;
   logic warn_q;
   logic thermal_q;
   logic gvdd_low_q;
   logic vdd_low_q;
   logic supplies_up_q;

   logic overload_latch;
   logic undervoltage_guard;
   logic thermal_shutdown;
   logic power_on_clear;
   logic reset_rise;
   logic [asps_pkg::CHANNELS-1:0] ch_enable;
   logic [asps_pkg::CHANNELS-1:0] ch_limiting;
   logic [asps_pkg::CHANNELS-1:0] ch_persist;
   logic [asps_pkg::CHANNELS-1:0] ch_high;
   logic [asps_pkg::CHANNELS-1:0] ch_low;
   logic sw_enable;
   logic [asps_pkg::TRIP_W-1:0] trip_count;
   asps_pkg::asps_state_e state;
   asps_pkg::asps_state_e next_state;

   logic dp_write;
   logic dp_valid;
   logic [asps_pkg::ADDR_DEC_W-1:0] dp_addr;
   logic addr_ok;
   logic [31:0] read_word;

   // every pin and comparator output passes two flip-flops
   assign raw_in = {reset_pin_n_i, bias_mode_select_i, pwm_i, overcurrent_high_i,
                    overcurrent_low_i, temp_warning_level_i, thermal_shutdown_level_i,
                    gate_drive_supply_low_i, common_supply_low_i, supplies_up_i};

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         sync_meta <= '0;
         sync_q <= '0;
      end else begin
         sync_meta <= raw_in;
         sync_q <= sync_meta;
      end
   end

   assign {reset_pin_q, mode_q, pwm_q, oc_high_q, oc_low_q, warn_q, thermal_q,
           gvdd_low_q, vdd_low_q, supplies_up_q} = sync_q;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         reset_pin_prev <= 1'b0;
      end else begin
         reset_pin_prev <= reset_pin_q;
      end
   end

   assign reset_rise = reset_pin_q && !reset_pin_prev;

   // fault conditions that recover on their own
   assign power_on_clear = !supplies_up_q;
   assign undervoltage_guard = gvdd_low_q || vdd_low_q;
   assign thermal_shutdown = thermal_q;

   // overload latch: set wins over the reset-edge clear
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         overload_latch <= 1'b0;
      end else if (|ch_persist) begin
         overload_latch <= 1'b1;
      end else if (power_on_clear) begin
         overload_latch <= 1'b0;
      end else if (reset_rise) begin
         overload_latch <= 1'b0;
      end
   end

   // start-up sequencer driven by mode select and reset levels
   always_comb begin
      next_state = asps_pkg::ASPS_OFF;
      if (!reset_pin_q) begin
         if (mode_q) begin
            next_state = asps_pkg::ASPS_PRECHARGE;
         end else begin
            next_state = asps_pkg::ASPS_OFF;
         end
      // the clearing edge releases the stage without a stray one-cycle shutdown flag
      end else if ((overload_latch && !reset_rise) || thermal_shutdown || undervoltage_guard ||
                   power_on_clear || (|ch_persist)) begin
         next_state = asps_pkg::ASPS_SHUTDOWN;
      end else begin
         next_state = asps_pkg::ASPS_RUN;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state <= asps_pkg::ASPS_OFF;
      end else begin
         state <= next_state;
      end
   end

   // channel enables; D-F only in six-channel mode
   always_comb begin
      ch_enable = '0;
      if (state == asps_pkg::ASPS_RUN && next_state == asps_pkg::ASPS_RUN && sw_enable) begin
         for (int i = 0; i < asps_pkg::CHANNELS; i++) begin
            if (i < asps_pkg::HALF_CHANNELS || mode_q) begin
               ch_enable[i] = 1'b1;
            end
         end
      end
   end

   // one limiter per half-bridge, one detector per transistor
   for (genvar g = 0; g < asps_pkg::CHANNELS; g++) begin : g_ch
      asps_oc_limiter #(
         .OVERLOAD_CYCLES(OVERLOAD_CYCLES)
      ) u_limiter (
         .clk_i(clk_i),
         .rst_n_i(rst_n_i),
         .enable_i(ch_enable[g]),
         .pwm_i(pwm_q[g]),
         .oc_high_i(oc_high_q[g]),
         .oc_low_i(oc_low_q[g]),
         .high_on_o(ch_high[g]),
         .low_on_o(ch_low[g]),
         .limiting_o(ch_limiting[g]),
         .persist_o(ch_persist[g])
      );
   end

   // limiter drive is cut at once when the stage leaves run
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         high_on_o <= '0;
         low_on_o <= '0;
      end else if (next_state != asps_pkg::ASPS_RUN) begin
         high_on_o <= '0;
         low_on_o <= '0;
      end else begin
         high_on_o <= ch_high & ch_enable;
         low_on_o <= ch_low & ch_enable;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         bias_precharge_control_o <= 1'b0;
      end else begin
         bias_precharge_control_o <= (next_state == asps_pkg::ASPS_PRECHARGE);
      end
   end

   // status pins, both forced high while reset pin is low
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         fault_shutdown_n_o <= 1'b1;
         temp_warning_n_o <= 1'b1;
      end else if (!reset_pin_q) begin
         fault_shutdown_n_o <= 1'b1;
         temp_warning_n_o <= 1'b1;
      end else begin
         fault_shutdown_n_o <= !(next_state == asps_pkg::ASPS_SHUTDOWN);
         temp_warning_n_o <= !(warn_q || thermal_q);
      end
   end

   // overload trip counter for software
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         trip_count <= '0;
      end else if ((|ch_persist) && !overload_latch) begin
         if (trip_count != '1) begin
            trip_count <= trip_count + 1'b1;
         end
      end else if (dp_valid && dp_write && dp_addr == asps_pkg::ADDR_CTRL &&
                   hwdata_i[asps_pkg::CTRL_CLR_TRIPS_BIT]) begin
         trip_count <= '0;
      end
   end

   // ahb-lite slave, zero wait states, always okay
   assign addr_ok = (haddr_i[31:asps_pkg::ADDR_DEC_W] == '0);

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         dp_valid <= 1'b0;
         dp_write <= 1'b0;
         dp_addr <= '0;
      end else if (hready_i) begin
         dp_valid <= hsel_i && htrans_i == asps_pkg::HTRANS_NONSEQ &&
                     hsize_i == asps_pkg::HSIZE_WORD && addr_ok;
         dp_write <= hwrite_i;
         dp_addr <= haddr_i[asps_pkg::ADDR_DEC_W-1:0];
      end else begin
         dp_valid <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         sw_enable <= asps_pkg::CTRL_ENABLE_RESET;
      end else if (dp_valid && dp_write && dp_addr == asps_pkg::ADDR_CTRL) begin
         sw_enable <= hwdata_i[asps_pkg::CTRL_ENABLE_BIT];
      end
   end

   always_comb begin
      read_word = '0;
      unique case (haddr_i[asps_pkg::ADDR_DEC_W-1:0])
         asps_pkg::ADDR_CTRL: begin
            read_word[asps_pkg::CTRL_ENABLE_BIT] = sw_enable;
         end
         asps_pkg::ADDR_STATUS: begin
            read_word[asps_pkg::ST_OVERLOAD_BIT] = overload_latch;
            read_word[asps_pkg::ST_THERMAL_BIT] = thermal_shutdown;
            read_word[asps_pkg::ST_WARNING_BIT] = warn_q;
            read_word[asps_pkg::ST_UNDERVOLT_BIT] = undervoltage_guard;
            read_word[asps_pkg::ST_POR_BIT] = power_on_clear;
            read_word[asps_pkg::ST_RESET_PIN_BIT] = reset_pin_q;
            read_word[asps_pkg::ST_MODE_BIT] = mode_q;
            read_word[asps_pkg::ST_STATE_LSB +: 4] = state;
            read_word[asps_pkg::ST_LIMIT_LSB +: asps_pkg::CHANNELS] = ch_limiting;
         end
         asps_pkg::ADDR_TRIPS: begin
            read_word[asps_pkg::TRIP_W-1:0] = trip_count;
         end
         default: begin
            read_word = '0;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         hrdata_o <= '0;
      end else if (hready_i && hsel_i && htrans_i == asps_pkg::HTRANS_NONSEQ &&
                   !hwrite_i && addr_ok && hsize_i == asps_pkg::HSIZE_WORD) begin
         hrdata_o <= read_word;
      end else if (hready_i) begin
         hrdata_o <= '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         hreadyout_o <= 1'b1;
         hresp_o <= asps_pkg::HRESP_OKAY;
      end else begin
         hreadyout_o <= 1'b1;
         hresp_o <= asps_pkg::HRESP_OKAY;
      end
   end
endmodule

// >>> tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
   localparam int unsigned OVL = 20;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [5:0] pwm = 6'h00, och = 6'h00, ocl = 6'h00, hi, lo;
   logic warn = 1'b0, hot = 1'b0, gdl = 1'b0, cml = 1'b0, sup = 1'b1;
   logic hsel = 1'b0, hw = 1'b0, smp = 1'b0, rdv = 1'b0, clr = 1'b0;
   logic [31:0] ha = 32'h0, hwd = 32'h0, hrd, q[$];
   logic [1:0] ht = 2'b00, ph = 2'b00;
   logic [2:0] hs = 3'b000;
   logic rp, md, bias, sd, temp_warning_n, rdy, hresp;
   int fails = 0, check_count = 0;
   always #5 clk_i = ~clk_i;
   asps_top #(.OVERLOAD_CYCLES(OVL)) dut (.clk_i, .rst_n_i, .reset_pin_n_i(rp),
      .bias_mode_select_i(md), .pwm_i(pwm), .overcurrent_high_i(och), .overcurrent_low_i(ocl),
      .temp_warning_level_i(warn), .thermal_shutdown_level_i(hot), .supplies_up_i(sup),
      .gate_drive_supply_low_i(gdl), .common_supply_low_i(cml), .high_on_o(hi), .low_on_o(lo),
      .bias_precharge_control_o(bias), .fault_shutdown_n_o(sd), .temp_warning_n_o(temp_warning_n),
      .hsel_i(hsel), .haddr_i(ha), .htrans_i(ht), .hwrite_i(hw), .hsize_i(hs), .hwdata_i(hwd),
      .hready_i(rdy), .hreadyout_o(rdy), .hresp_o(hresp), .hrdata_o(hrd));
   asps_ctl_model ctl (.clk_i, .rst_n_i, .phase_i(ph), .clear_i(clr), .fault_shutdown_n_i(sd),
      .reset_pin_n_o(rp), .bias_mode_select_o(md));
   function automatic logic [31:0] pv(input logic b, s, o, input logic [5:0] h, l);
      pv = {17'h0, b, s, o, h, l};
   endfunction
   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic pins(input logic [31:0] e);
      q.push_back(e);
      smp <= 1'b1;
      wt(1);
      smp <= 1'b0;
   endtask
   task automatic idle(input logic b, s, o);
      pins(pv(b, s, o, 6'h00, 6'h00));
   endtask
   task automatic run(input logic [5:0] m);
      pins(pv(1'b0, 1'b1, 1'b1, pwm & m, ~pwm & m));
   endtask
   task automatic rdy_wait();
      int n;
      for (n = 0; n < 9; n++) begin
         wt(1);
         if (rdy === 1'b1) break;
      end
      if (n == 9) begin
         fails++;
         report_and_stop();
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      ha <= {24'h0, a};
      ht <= asps_pkg::HTRANS_NONSEQ;
      hw <= w;
      hs <= asps_pkg::HSIZE_WORD;
      rdy_wait();
      hsel <= 1'b0;
      ht <= 2'b00;
      hwd <= d;
      rdv <= !w;
      if (!w) q.push_back(d);
      rdy_wait();
      rdv <= 1'b0;
   endtask
   // limiting held past the persistence count, then detector released
   task automatic overload();
      pwm <= 6'h3f;
      wt(6);
      och <= 6'h01;
      wt(OVL + 8);
      och <= 6'h00;
      pwm <= 6'h00;
      wt(6);
      idle(1'b0, 1'b0, 1'b1);
   endtask
   always @(negedge clk_i) begin
      if (smp) `CHK(pv(bias, sd, temp_warning_n, hi, lo), q.pop_front())
      // read data is taken only in the cycle whose closing edge sees hready high
      if (rdv && rdy) begin
         `CHK(hrd, q.pop_front())
         `CHK(hresp, asps_pkg::HRESP_OKAY)
      end
   end
   initial begin
      wt(60000);
      fails++;
      report_and_stop();
   end
   initial begin
      logic [5:0] r;
      int k;
      r = 6'($urandom(25809));
      wt(5);
      rst_n_i <= 1'b1;
      hot <= 1'b1;
      wt(6);
      idle(1'b0, 1'b1, 1'b1);
      hot <= 1'b0;
      ph <= 2'h1;
      wt(6);
      idle(1'b1, 1'b1, 1'b1);
      ph <= 2'h2;
      for (k = 0; k < 4; k++) begin
         pwm <= 6'($urandom);
         wt(7);
         run(6'h3f);
      end
      warn <= 1'b1;
      wt(6);
      pins(pv(1'b0, 1'b1, 1'b0, pwm, ~pwm));
      warn <= 1'b0;
      for (k = 0; k < 3; k++) begin
         {cml, gdl, hot} <= 3'(1 << k);
         wt(6);
         idle(1'b0, 1'b0, k != 0);
         {cml, gdl, hot} <= 3'h0;
         wt(6);
         run(6'h3f);
      end
      for (k = 0; k < 12; k++) begin
         r = 6'h01 << (k % 6);
         pwm <= (k < 6) ? 6'h00 : 6'h3f;
         wt(4);
         pwm <= ~pwm;
         wt(6);
         if (k < 6) och <= r;
         else ocl <= r;
         wt(5);
         och <= 6'h00;
         ocl <= 6'h00;
         pins(pv(1'b0, 1'b1, 1'b1, pwm & ~r, ~pwm & ~r));
      end
      overload();
      ahb(1'b0, asps_pkg::ADDR_STATUS, 32'h0000_0861);
      ahb(1'b0, asps_pkg::ADDR_TRIPS, 32'h0000_0001);
      ahb(1'b0, 8'h0c, 32'h0000_0000);
      ahb(1'b1, asps_pkg::ADDR_CTRL, 32'h0000_0003);
      ahb(1'b0, asps_pkg::ADDR_TRIPS, 32'h0000_0000);
      pwm <= 6'($urandom);
      clr <= 1'b1;
      wt(12);
      clr <= 1'b0;
      run(6'h3f);
      overload();
      sup <= 1'b0;
      wt(6);
      sup <= 1'b1;
      pwm <= 6'($urandom);
      wt(9);
      run(6'h3f);
      ph <= 2'h0;
      wt(6);
      ph <= 2'h1;
      wt(6);
      ph <= 2'h3;
      wt(8);
      run(6'h07);
      report_and_stop();
   end
endmodule
